// *** logic/ea_size_defs.svh ***
// constants of the operand/address size select and effective address block
`ifndef EA_SIZE_DEFS_SVH
`define EA_SIZE_DEFS_SVH
// register byte offsets
`define ADDR_CTRL       8'h00
`define ADDR_BASE       8'h04
`define ADDR_INDEX      8'h08
`define ADDR_DISP       8'h0C
`define ADDR_CMD        8'h10
`define ADDR_STATUS     8'h14
`define ADDR_EA         8'h18
`define ADDR_STRCNT     8'h1C
`define ADDR_FMT_LO     8'h20
`define ADDR_FMT_MID    8'h24
`define ADDR_FMT_HI     8'h28
`define ADDR_FMT_SEL    8'h2C
`define ADDR_FMT_SIGN   8'h30
`define ADDR_FMT_EXP    8'h34
`define ADDR_FMT_SIG_LO 8'h38
`define ADDR_FMT_SIG_HI 8'h3C
`define ADDR_FMT_AUX    8'h40
// field positions
`define CMD_START_BIT   0
`define ST_BUSY_BIT     0
`define ST_DONE_BIT     1
`define ST_GP_BIT       2
`define ST_REGF_BIT     3
`define ST_OP32_BIT     4
`define ST_ADDR32_BIT   5
`define SGN_SIGN_BIT    0
`define SGN_INTBIT_BIT  1
`define SGN_CPU_OK_BIT  2
`define SGN_FPU_OK_BIT  3
`define SGL_SIGN        31
`define SGL_EXP_MSB     30
`define SGL_EXP_LSB     23
`define SGL_SIG_MSB     22
`define DBL_SIGN        63
`define DBL_EXP_MSB     62
`define DBL_EXP_LSB     52
`define DBL_SIG_MSB     51
`define EXT_SIGN        79
`define EXT_EXP_MSB     78
`define EXT_EXP_LSB     64
`define EXT_SIG_MSB     63
`define BCD_LO_MSB      3
`define BCD_HI_LSB      4
`define BCD_HI_MSB      7
// reset values and limits
`define RST_WORD        32'h0000_0000
`define REAL_LIMIT      32'h0000_FFFF
// general register numbers
`define REGNUM_SP       3'h4
`define REGNUM_BASE_A   3'h3
`define REGNUM_FRAME    3'h5
`define REGNUM_SRC_IDX  3'h6
`define REGNUM_DEST_IDX 3'h7
// displacement size codes
`define DISP_NONE       2'h0
`define DISP_BYTE       2'h1
`define DISP_WIDE       2'h2
`endif

// *** logic/ea_size_pkg.sv ***
// types of the operand/address size select and effective address block
package ea_size_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_CALC  = 2'h1,
      ST_EXTRA = 2'h3
   } state_t;
   typedef struct packed {
      logic [12:0] rsvd2;
      logic [2:0]  index_sel;
      logic        rsvd1;
      logic [2:0]  base_sel;
      logic [1:0]  rsvd0;
      logic [1:0]  disp_size;
      logic        index_en;
      logic        base_en;
      logic [1:0]  scale;
      logic        addr_prefix;
      logic        op_prefix;
      logic        real_mode;
      logic        code_size;
   } ctrl_t;
   typedef enum logic [3:0] {
      FMT_SINGLE = 4'h0, FMT_DOUBLE = 4'h1, FMT_EXT  = 4'h2, FMT_BCD80 = 4'h3,
      FMT_INT8   = 4'h4, FMT_INT16  = 4'h5, FMT_INT32 = 4'h6, FMT_INT64 = 4'h7,
      FMT_UBYTE  = 4'h8, FMT_UWORD  = 4'h9, FMT_UDWORD = 4'hA, FMT_UNPK_BCD = 4'hB,
      FMT_PK_BCD = 4'hC, FMT_LONG_PTR = 4'hD, FMT_SHORT_PTR = 4'hE, FMT_NONE = 4'hF
   } fmt_sel_t;
   // string length held as count minus one: 1 byte up to 4 Gbytes or 4 Gbits
   typedef logic [31:0] str_cnt_t;
   typedef struct packed {
      logic [15:0] selector;
      logic [31:0] offset;
   } long_ptr_t;
   typedef struct packed {
      logic        sign;
      logic [14:0] exp;
      logic [63:0] sig;
      logic [7:0]  aux;
      logic        int_bit;
      logic        cpu_ok;
      logic        fpu_ok;
   } fmt_fields_t;
endpackage

// *** logic/ea_size_select.sv ***
// operand/address size select, effective address unit and data format decoder
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ea_size_defs.svh"
module ea_size_select (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // status lines
   output logic             busy_o,
   output logic             gp_fault_o
);
   // apb state
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   // software registers
   ea_size_pkg::ctrl_t    ctrl_reg, ctrl_next;
   logic [31:0]           base_reg, base_next;
   logic [31:0]           index_reg, index_next;
   logic [31:0]           disp_reg, disp_next;
   ea_size_pkg::str_cnt_t strcnt_reg, strcnt_next;
   logic [31:0]           fmt_lo_reg, fmt_lo_next;
   logic [31:0]           fmt_mid_reg, fmt_mid_next;
   logic [15:0]           fmt_hi_reg, fmt_hi_next;
   logic [3:0]            fmt_sel_reg, fmt_sel_next;
   // engine state
   ea_size_pkg::state_t state_reg, state_next;
   logic [31:0] ea_reg, ea_next;
   logic        done_reg, done_next;
   logic        gp_reg, gp_next;
   logic        regf_reg, regf_next;
   logic        op32_reg, op32_next;
   logic        addr32_reg, addr32_next;
   logic        busy_reg, busy_next;
   // decoded format fields
   ea_size_pkg::fmt_fields_t fmt_reg, fmt_next;

   // combinational helpers
   logic        access, commit, busy_now, start;
   logic        def32, op32, addr32, both_used, reg_fault, gp_hit;
   logic [31:0] base_v, index_v, disp_v, sum, ea_val;
   logic [79:0] fv;

   // byte-lane merge for apb writes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // size decode from descriptor flag, mode and prefixes
   always_comb begin
      def32  = ctrl_reg.code_size & ~ctrl_reg.real_mode;
      op32   = def32 ^ ctrl_reg.op_prefix;
      addr32 = def32 ^ ctrl_reg.addr_prefix;
      both_used = ctrl_reg.base_en & ctrl_reg.index_en;
   end

   // operand legality and effective address sum
   always_comb begin
      reg_fault = (ctrl_reg.disp_size == 2'h3);
      if (addr32) begin
         // stack pointer cannot index
         if (ctrl_reg.index_en && ctrl_reg.index_sel == `REGNUM_SP) begin
            reg_fault = 1'b1;
         end
      end else begin
         // only legacy pairs, and no scaling, in 16-bit mode
         if (ctrl_reg.base_en && ctrl_reg.base_sel != `REGNUM_BASE_A
             && ctrl_reg.base_sel != `REGNUM_FRAME) begin
            reg_fault = 1'b1;
         end
         if (ctrl_reg.index_en && ctrl_reg.index_sel != `REGNUM_SRC_IDX
             && ctrl_reg.index_sel != `REGNUM_DEST_IDX) begin
            reg_fault = 1'b1;
         end
         if (ctrl_reg.scale != 2'h0) begin
            reg_fault = 1'b1;
         end
      end
      // displacement: 8 bits, or 32/16 by address size, sign-extended
      case (ctrl_reg.disp_size)
         `DISP_BYTE: disp_v = {{24{disp_reg[7]}}, disp_reg[7:0]};
         `DISP_WIDE: disp_v = addr32 ? disp_reg : {{16{disp_reg[15]}}, disp_reg[15:0]};
         default:    disp_v = 32'h0000_0000;
      endcase
      base_v  = 32'h0000_0000;
      index_v = 32'h0000_0000;
      if (ctrl_reg.base_en) begin
         base_v = addr32 ? base_reg : {16'h0000, base_reg[15:0]};
      end
      if (ctrl_reg.index_en) begin
         index_v = addr32 ? (index_reg << ctrl_reg.scale)
                          : {16'h0000, index_reg[15:0]};
      end
      sum = base_v + index_v + disp_v;
      // real mode may compute 32 bits under a prefix but never reach past 64K
      gp_hit = ctrl_reg.real_mode & addr32 & (sum > `REAL_LIMIT) & ~reg_fault;
      ea_val = addr32 ? sum : {16'h0000, sum[15:0]};
   end

   // apb request decode: write lands at the edge that samples pready high
   always_comb begin
      access   = psel_i & penable_i;
      commit   = access & pready_reg & pwrite_i & ~pslverr_reg;
      busy_now = (state_reg != ea_size_pkg::ST_IDLE);
      start    = commit && paddr_i == `ADDR_CMD && pstrb_i[0]
                 && pwdata_i[`CMD_START_BIT] && !busy_now;
   end

   // apb answer: one wait state, error on unmapped or busy-time engine writes
   always_comb begin
      pready_next  = access & ~pready_reg;
      pslverr_next = 1'b0;
      prdata_next  = prdata_reg;
      if (access && !pready_reg) begin
         prdata_next = 32'h0000_0000;
         case (paddr_i)
            `ADDR_CTRL:       prdata_next = ctrl_reg & 32'h0007_73FF;
            `ADDR_BASE:       prdata_next = base_reg;
            `ADDR_INDEX:      prdata_next = index_reg;
            `ADDR_DISP:       prdata_next = disp_reg;
            `ADDR_CMD:        prdata_next = 32'h0000_0000;
            `ADDR_STATUS: begin
               prdata_next[`ST_BUSY_BIT]   = busy_now;
               prdata_next[`ST_DONE_BIT]   = done_reg;
               prdata_next[`ST_GP_BIT]     = gp_reg;
               prdata_next[`ST_REGF_BIT]   = regf_reg;
               prdata_next[`ST_OP32_BIT]   = op32_reg;
               prdata_next[`ST_ADDR32_BIT] = addr32_reg;
            end
            `ADDR_EA:         prdata_next = ea_reg;
            `ADDR_STRCNT:     prdata_next = strcnt_reg;
            `ADDR_FMT_LO:     prdata_next = fmt_lo_reg;
            `ADDR_FMT_MID:    prdata_next = fmt_mid_reg;
            `ADDR_FMT_HI:     prdata_next = {16'h0000, fmt_hi_reg};
            `ADDR_FMT_SEL:    prdata_next = {28'h000_0000, fmt_sel_reg};
            `ADDR_FMT_SIGN: begin
               prdata_next[`SGN_SIGN_BIT]   = fmt_reg.sign;
               prdata_next[`SGN_INTBIT_BIT] = fmt_reg.int_bit;
               prdata_next[`SGN_CPU_OK_BIT] = fmt_reg.cpu_ok;
               prdata_next[`SGN_FPU_OK_BIT] = fmt_reg.fpu_ok;
            end
            `ADDR_FMT_EXP:    prdata_next = {17'h0_0000, fmt_reg.exp};
            `ADDR_FMT_SIG_LO: prdata_next = fmt_reg.sig[31:0];
            `ADDR_FMT_SIG_HI: prdata_next = fmt_reg.sig[63:32];
            `ADDR_FMT_AUX:    prdata_next = {24'h00_0000, fmt_reg.aux};
            default:          pslverr_next = 1'b1;
         endcase
         // engine inputs are frozen while a calculation runs
         if (pwrite_i && busy_now && paddr_i <= `ADDR_CMD) begin
            pslverr_next = 1'b1;
         end
      end
   end

   // software register writes
   always_comb begin
      ctrl_next    = ctrl_reg;
      base_next    = base_reg;
      index_next   = index_reg;
      disp_next    = disp_reg;
      strcnt_next  = strcnt_reg;
      fmt_lo_next  = fmt_lo_reg;
      fmt_mid_next = fmt_mid_reg;
      fmt_hi_next  = fmt_hi_reg;
      fmt_sel_next = fmt_sel_reg;
      if (commit) begin
         case (paddr_i)
            `ADDR_CTRL:    ctrl_next    = merge(ctrl_reg, pwdata_i, pstrb_i) & 32'h0007_73FF;
            `ADDR_BASE:    base_next    = merge(base_reg, pwdata_i, pstrb_i);
            `ADDR_INDEX:   index_next   = merge(index_reg, pwdata_i, pstrb_i);
            `ADDR_DISP:    disp_next    = merge(disp_reg, pwdata_i, pstrb_i);
            `ADDR_STRCNT:  strcnt_next  = merge(strcnt_reg, pwdata_i, pstrb_i);
            `ADDR_FMT_LO:  fmt_lo_next  = merge(fmt_lo_reg, pwdata_i, pstrb_i);
            `ADDR_FMT_MID: fmt_mid_next = merge(fmt_mid_reg, pwdata_i, pstrb_i);
            `ADDR_FMT_HI:  fmt_hi_next  = pwdata_i[15:0];
            `ADDR_FMT_SEL: fmt_sel_next = pwdata_i[3:0];
            default: begin
            end
         endcase
      end
   end

   // calculation sequencer; results land when the sequence returns to idle
   always_comb begin
      state_next  = state_reg;
      ea_next     = ea_reg;
      done_next   = done_reg;
      gp_next     = gp_reg;
      regf_next   = regf_reg;
      op32_next   = op32_reg;
      addr32_next = addr32_reg;
      case (state_reg)
         ea_size_pkg::ST_IDLE: begin
            if (start) begin
               state_next = ea_size_pkg::ST_CALC;
               done_next  = 1'b0;
            end
         end
         ea_size_pkg::ST_CALC: begin
            if (both_used) begin
               state_next = ea_size_pkg::ST_EXTRA;
            end else begin
               state_next = ea_size_pkg::ST_IDLE;
            end
         end
         ea_size_pkg::ST_EXTRA: state_next = ea_size_pkg::ST_IDLE;
         default:               state_next = ea_size_pkg::ST_IDLE;
      endcase
      if ((state_reg == ea_size_pkg::ST_CALC && !both_used)
          || state_reg == ea_size_pkg::ST_EXTRA) begin
         done_next   = 1'b1;
         gp_next     = gp_hit;
         regf_next   = reg_fault;
         op32_next   = op32;
         addr32_next = addr32;
         // a faulting access reports no address
         ea_next = (gp_hit || reg_fault) ? 32'h0000_0000 : ea_val;
      end
      busy_next = (state_next != ea_size_pkg::ST_IDLE);
   end

   // data format field extraction from the 80-bit probe value
   always_comb begin
      fv = {fmt_hi_reg, fmt_mid_reg, fmt_lo_reg};
      fmt_next = '0;
      case (fmt_sel_reg)
         ea_size_pkg::FMT_SINGLE: begin
            fmt_next.sign = fv[`SGL_SIGN];
            fmt_next.exp  = {7'h00, fv[`SGL_EXP_MSB:`SGL_EXP_LSB]};
            fmt_next.sig  = {41'h0, fv[`SGL_SIG_MSB:0]};
            fmt_next.fpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_DOUBLE: begin
            fmt_next.sign = fv[`DBL_SIGN];
            fmt_next.exp  = {4'h0, fv[`DBL_EXP_MSB:`DBL_EXP_LSB]};
            fmt_next.sig  = {12'h000, fv[`DBL_SIG_MSB:0]};
            fmt_next.fpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_EXT: begin
            fmt_next.sign    = fv[`EXT_SIGN];
            fmt_next.exp     = fv[`EXT_EXP_MSB:`EXT_EXP_LSB];
            fmt_next.sig     = fv[`EXT_SIG_MSB:0];
            fmt_next.int_bit = fv[`EXT_SIG_MSB];
            fmt_next.fpu_ok  = 1'b1;
         end
         ea_size_pkg::FMT_BCD80: begin
            fmt_next.sign   = fv[`EXT_SIGN];
            fmt_next.sig    = fv[63:0];
            fmt_next.aux    = fv[7:0];
            fmt_next.fpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_INT8: begin
            fmt_next.sign   = fv[7];
            fmt_next.sig    = {{56{fv[7]}}, fv[7:0]};
            fmt_next.cpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_INT16: begin
            fmt_next.sign   = fv[15];
            fmt_next.sig    = {{48{fv[15]}}, fv[15:0]};
            fmt_next.cpu_ok = 1'b1;
            fmt_next.fpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_INT32: begin
            fmt_next.sign   = fv[31];
            fmt_next.sig    = {{32{fv[31]}}, fv[31:0]};
            fmt_next.cpu_ok = 1'b1;
            fmt_next.fpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_INT64: begin
            fmt_next.sign   = fv[63];
            fmt_next.sig    = fv[63:0];
            fmt_next.fpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_UBYTE: begin
            fmt_next.sig    = {56'h0, fv[7:0]};
            fmt_next.cpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_UWORD: begin
            fmt_next.sig    = {48'h0, fv[15:0]};
            fmt_next.cpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_UDWORD: begin
            fmt_next.sig    = {32'h0, fv[31:0]};
            fmt_next.cpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_UNPK_BCD: begin
            fmt_next.aux    = {4'h0, fv[`BCD_LO_MSB:0]};
            fmt_next.cpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_PK_BCD: begin
            fmt_next.aux    = {fv[`BCD_HI_MSB:`BCD_HI_LSB], fv[`BCD_LO_MSB:0]};
            fmt_next.cpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_LONG_PTR: begin
            fmt_next.exp    = fv[46:32];
            fmt_next.sig    = {16'h0000, fv[47:0]};
            fmt_next.cpu_ok = 1'b1;
         end
         ea_size_pkg::FMT_SHORT_PTR: begin
            fmt_next.sig    = {32'h0, fv[31:0]};
            fmt_next.cpu_ok = 1'b1;
         end
         default: fmt_next = '0;
      endcase
   end

   // all state registered; synchronous reset to defined values
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= `RST_WORD;
         ctrl_reg    <= `RST_WORD;
         base_reg    <= `RST_WORD;
         index_reg   <= `RST_WORD;
         disp_reg    <= `RST_WORD;
         strcnt_reg  <= `RST_WORD;
         fmt_lo_reg  <= `RST_WORD;
         fmt_mid_reg <= `RST_WORD;
         fmt_hi_reg  <= 16'h0000;
         fmt_sel_reg <= 4'h0;
         state_reg   <= ea_size_pkg::ST_IDLE;
         ea_reg      <= `RST_WORD;
         done_reg    <= 1'b0;
         gp_reg      <= 1'b0;
         regf_reg    <= 1'b0;
         op32_reg    <= 1'b0;
         addr32_reg  <= 1'b0;
         busy_reg    <= 1'b0;
         fmt_reg     <= '0;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
         ctrl_reg    <= ctrl_next;
         base_reg    <= base_next;
         index_reg   <= index_next;
         disp_reg    <= disp_next;
         strcnt_reg  <= strcnt_next;
         fmt_lo_reg  <= fmt_lo_next;
         fmt_mid_reg <= fmt_mid_next;
         fmt_hi_reg  <= fmt_hi_next;
         fmt_sel_reg <= fmt_sel_next;
         state_reg   <= state_next;
         ea_reg      <= ea_next;
         done_reg    <= done_next;
         gp_reg      <= gp_next;
         regf_reg    <= regf_next;
         op32_reg    <= op32_next;
         addr32_reg  <= addr32_next;
         busy_reg    <= busy_next;
         fmt_reg     <= fmt_next;
      end
   end

   // outputs straight from flip-flops
   assign prdata_o   = prdata_reg;
   assign pready_o   = pready_reg;
   assign pslverr_o  = pslverr_reg;
   assign busy_o     = busy_reg;
   assign gp_fault_o = gp_reg;
endmodule
`default_nettype wire

// *** testbench/ea_size_select_sva.sv ***
// concurrent checks on the size select block ports
`timescale 1ns/1ps
`default_nettype none
`include "ea_size_defs.svh"
module ea_size_select_sva (
   // clock and reset
   input wire logic        clock_i,
   input wire logic        rst_i,
   // apb side
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // status lines
   input wire logic        busy_o,
   input wire logic        gp_fault_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // a committed, unrefused write of the start bit
   sequence s_start;
      psel_i && penable_i && pwrite_i && pready_o && !pslverr_o
         && paddr_i == `ADDR_CMD && pwdata_i[`CMD_START_BIT];
   endsequence
   // two running cycles in a row, the most any calculation may take
   sequence s_long;
      busy_o ##1 busy_o;
   endsequence
   property p_ans; psel_i && penable_i && !pready_o |=> pready_o; endproperty
   property p_pulse; pready_o |=> !pready_o; endproperty
   property p_err; pslverr_o |-> pready_o; endproperty
   property p_unmap; psel_i && penable_i && !pready_o && paddr_i > 8'h40 |=> pslverr_o;
   endproperty
   property p_rderr; pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000;
   endproperty
   property p_start; s_start and !busy_o |=> busy_o; endproperty
   property p_lat; s_long |=> !busy_o; endproperty
   property p_gp; $changed(gp_fault_o) |-> $fell(busy_o); endproperty
   a_ans: assert property (p_ans) else $error("access phase not answered");
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   a_err: assert property (p_err) else $error("error without ready");
   a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
   a_rderr: assert property (p_rderr) else $error("refused read not zero");
   a_start: assert property (p_start) else $error("start did not begin run");
   a_lat: assert property (p_lat) else $error("calculation too long");
   a_gp: assert property (p_gp) else $error("fault flag moved mid run");
endmodule
bind ea_size_select ea_size_select_sva u_sva (
   .clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
   .prdata_o, .pready_o, .pslverr_o, .busy_o, .gp_fault_o
);
`default_nettype wire

// *** testbench/ea_size_select_test.sv ***
// self-checking bench for the size select block
`timescale 1ns/1ps
`default_nettype none
`include "ea_size_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module ea_size_select_test;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [3:0]  pstrb_i = 4'hF;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        busy_o;
   logic        gp_fault_o;
   logic [31:0] rd;
   logic        err;
   int          n_fail = 0;
   int          cmp_count = 0;
   ea_size_select dut (
      .clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
      .prdata_o, .pready_o, .pslverr_o, .busy_o, .gp_fault_o
   );
   // 200 MHz core clock
   initial begin
      forever #2.5 clock_i = ~clock_i;
   end
   // one apb transfer; an idle edge follows so a next setup never collides
   // the access phase waits for pready however long it takes: only the watchdog ends it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e);
   endtask
   task automatic ops(input logic [31:0] b, input logic [31:0] x, input logic [31:0] d);
      apb(1'b1, `ADDR_BASE, b);
      apb(1'b1, `ADDR_INDEX, x);
      apb(1'b1, `ADDR_DISP, d);
   endtask
   // run one calculation and count the cycles it keeps the block busy
   task automatic calc(input logic [31:0] c, input logic [31:0] ea, input logic [5:0] st,
                       input int lat);
      int n = 0;
      apb(1'b1, `ADDR_CTRL, c);
      apb(1'b1, `ADDR_CMD, 32'h0000_0001);
      while (busy_o === 1'b1 && n < 8) begin
         n++;
         @(posedge clock_i);
      end
      `CHK(n, lat);
      rdc(`ADDR_EA, ea);
      rdc(`ADDR_STATUS, {26'h000_0000, st});
      `CHK(gp_fault_o, st[2]);
   endtask
   task automatic fmt(input logic [3:0] s, input logic [31:0] lo, input logic [31:0] mid);
      apb(1'b1, `ADDR_FMT_LO, lo);
      apb(1'b1, `ADDR_FMT_MID, mid);
      apb(1'b1, `ADDR_FMT_HI, {16'h0000, lo[31:16]});
      apb(1'b1, `ADDR_FMT_SEL, {28'h000_0000, s});
   endtask
   task automatic stop_test();
      if (n_fail == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard, far beyond the few microseconds the sequence needs
   initial begin
      #20000;
      n_fail++;
      stop_test();
   end
   // main sequence
   initial begin
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      rdc(`ADDR_STATUS, 32'h0000_0000);
      apb(1'b1, 8'h44, 32'h0000_FFFF);
      `CHK(err, 1'b1);
      rdc(8'h44, 32'h0000_0000);
      `CHK(err, 1'b1);
      apb(1'b1, `ADDR_STRCNT, 32'hFFFF_FFFF);
      rdc(`ADDR_STRCNT, 32'hFFFF_FFFF);
      rdc(`ADDR_CMD, 32'h0000_0000);
      ops(32'h1000_0000, 32'h0000_0010, 32'hFFFF_FFF0);
      calc(32'h0001_02F1, 32'h1000_0070, 6'h32, 2);
      ops(32'h1234_0010, 32'h0001_0000, 32'h0000_0080);
      calc(32'h0000_3140, 32'h0000_FF90, 6'h02, 1);
      calc(32'h0002_009C, 32'h0002_0000, 6'h32, 1);
      ops(32'h0000_FFFF, 32'h0000_0000, 32'h0000_0002);
      calc(32'h0000_524D, 32'h0000_0001, 6'h02, 1);
      calc(32'h0000_004B, 32'h0000_FFFF, 6'h22, 1);
      ops(32'h0001_0000, 32'h0000_0000, 32'h0000_0002);
      calc(32'h0000_004B, 32'h0000_0000, 6'h26, 1);
      calc(32'h0004_0081, 32'h0000_0000, 6'h3A, 1);
      calc(32'h0007_0090, 32'h0000_0000, 6'h0A, 1);
      // value layouts: the high word also feeds the top 16 bits of the value
      fmt(4'h0, 32'h0000_C0A0, 32'h0000_0000);
      rdc(`ADDR_FMT_SIG_LO, 32'h0000_C0A0);
      fmt(4'h0, 32'hC0A0_0001, 32'h0000_0000);
      rdc(`ADDR_FMT_EXP, 32'h0000_0081);
      fmt(4'h1, 32'h0000_0005, 32'h3FF8_0000);
      rdc(`ADDR_FMT_EXP, 32'h0000_03FF);
      rdc(`ADDR_FMT_SIG_HI, 32'h0008_0000);
      fmt(4'h2, 32'hC000_0001, 32'h8000_0000);
      rdc(`ADDR_FMT_EXP, 32'h0000_4000);
      rdc(`ADDR_FMT_SIGN, 32'h0000_000B);
      fmt(4'h3, 32'h0000_0012, 32'h0000_0000);
      rdc(`ADDR_FMT_SIGN, 32'h0000_0008);
      fmt(4'hC, 32'h0000_0093, 32'h0000_0000);
      rdc(`ADDR_FMT_AUX, 32'h0000_0093);
      rdc(`ADDR_FMT_SIGN, 32'h0000_0004);
      fmt(4'h4, 32'h0000_0080, 32'h0000_0000);
      rdc(`ADDR_FMT_SIG_LO, 32'hFFFF_FF80);
      rdc(`ADDR_FMT_SIGN, 32'h0000_0005);
      fmt(4'h8, 32'h0000_0080, 32'h0000_0000);
      rdc(`ADDR_FMT_SIG_LO, 32'h0000_0080);
      fmt(4'hD, 32'h0000_5678, 32'h0000_ABCD);
      rdc(`ADDR_FMT_SIG_HI, 32'h0000_ABCD);
      fmt(4'hE, 32'h8765_4321, 32'h0000_1111);
      rdc(`ADDR_FMT_SIG_HI, 32'h0000_0000);
      rdc(`ADDR_FMT_SIG_LO, 32'h8765_4321);
      fmt(4'hB, 32'h0000_00F7, 32'h0000_0000);
      rdc(`ADDR_FMT_AUX, 32'h0000_0007);
      fmt(4'h7, 32'h0000_0000, 32'h8000_0000);
      rdc(`ADDR_FMT_SIGN, 32'h0000_0009);
      rdc(`ADDR_FMT_SIG_HI, 32'h8000_0000);
      // reset with the block idle must clear both software and decoded state
      rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      rdc(`ADDR_BASE, 32'h0000_0000);
      rdc(`ADDR_FMT_SIG_HI, 32'h0000_0000);
      rdc(`ADDR_STATUS, 32'h0000_0000);
      stop_test();
   end
endmodule
`default_nettype wire
